// file: common/occ_pkg.sv
package occ_pkg;

    // Register word addresses
    localparam logic [7:0] OCC_ADDR_HF_CTRL  = 8'h00;
    localparam logic [7:0] OCC_ADDR_LFX_CTRL = 8'h04;
    localparam logic [7:0] OCC_ADDR_LFR_CTRL = 8'h08;
    localparam logic [7:0] OCC_ADDR_ULP_CTRL = 8'h0c;
    localparam logic [7:0] OCC_ADDR_STATUS   = 8'h10;
    localparam logic [7:0] OCC_ADDR_IE_SET   = 8'h14;
    localparam logic [7:0] OCC_ADDR_IE_CLR   = 8'h18;
    localparam logic [7:0] OCC_ADDR_IRQ_FLAG = 8'h1c;

    // Control field positions
    localparam int OCC_B_ENABLE   = 1;
    localparam int OCC_B_XTAL     = 2;
    localparam int OCC_B_OUT32K   = 3;
    localparam int OCC_B_AUTOAMP  = 5;
    localparam int OCC_B_RUN_IN_STANDBY = 6;
    localparam int OCC_B_REQUEST_GATED_RUN = 7;
    localparam int OCC_GAIN_LSB   = 8;
    localparam int OCC_GAIN_W     = 3;
    localparam int OCC_HF_SEL_LSB = 12;
    localparam int OCC_LF_SEL_LSB = 8;
    localparam int OCC_SEL_W      = 4;
    localparam int OCC_TRIM_LSB   = 16;
    localparam int OCC_TRIM_W     = 7;
    localparam int OCC_ULP_TRIM_W = 5;

    // Status and interrupt bit positions
    localparam int OCC_ST_HF  = 0;
    localparam int OCC_ST_LFX = 1;
    localparam int OCC_ST_LFR = 2;
    localparam int OCC_NSRC   = 3;

    // Reset values
    localparam logic OCC_REQUEST_GATED_RUN_RST           = 1'b1;
    localparam logic [OCC_GAIN_W-1:0] OCC_GAIN_RST = 3'h0;
    localparam logic [OCC_SEL_W-1:0]  OCC_SEL_RST  = 4'h0;

    // Start-up unit in clock cycles, shifted left by settle_time_sel
    localparam int OCC_STARTUP_BASE = 16;
    localparam int OCC_CNT_W        = 24;

endpackage

// file: src/occ_osc_ctrl.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - After reset the fast oscillator is off and both its pins stay GPIO.
// - Fast oscillator in crystal mode takes over both its pins.
// - External-clock mode takes over only the input pin of an oscillator.
// - Enable bit starts fast oscillator; crystal_select one picks crystal.
// - auto_amplitude_ctrl set lets the fast oscillator regulate amplitude in crystal mode.
// - Enable clear means off; plain enable runs in idle, stops in standby.
// - request_gated_run runs only on request; standby needs run_in_standby. Code gates on request only in idle and standby; active always runs.
// - run_in_standby without request gating runs in idle and standby.
// - After reset or wake from off, output is masked for chosen start-up.
// - hf_xtal_ready sets once the chosen start-up time has elapsed.
// - Rising hf_xtal_ready raises an interrupt when its enable is set.
// - Slow crystal is off at power-on; crystal_select and pins as fast one.
// - Enabled slow crystal keeps running in every sleep mode.
// - Slow crystal masks start-up, then sets lf_xtal_ready and interrupt.
// - Slow crystal setup survives all resets except power-on reset.
// - out_32k_enable gives slow crystal 32k output in crystal mode only.
// - RC oscillator off by default; its out_32k_enable gates its output.
// - New RC freq_trim takes effect only once lf_rc_ready is high.
// - ULP oscillator always runs past power-on; trim loads then writable.
module occ_osc_ctrl
    import occ_pkg::*;
#(
    parameter logic [occ_pkg::OCC_CNT_W-1:0] STARTUP_BASE =
        occ_pkg::OCC_CNT_W'(occ_pkg::OCC_STARTUP_BASE)
)
(
    // Clock and resets: rst_in is power-on, sys_rst_in is any other reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        sys_rst_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Power state and peripheral demand
    input  wire logic        sleep_idle_in,
    input  wire logic        sleep_standby_in,
    input  wire logic        hf_clk_req_in,
    input  wire logic        lf_rc_clk_req_in,
    // Factory trim for the ULP oscillator
    input  wire logic [occ_pkg::OCC_ULP_TRIM_W-1:0] ulp_trim_fuse_in,
    // Fast crystal oscillator core and pins
    output logic        hf_osc_run_out,
    output logic        hf_xtal_mode_out,
    output logic [occ_pkg::OCC_GAIN_W-1:0] hf_drive_gain_out,
    output logic        hf_auto_amp_out,
    output logic        hf_clk_valid_out,
    output logic        hf_in_pin_override_out,
    output logic        hf_out_pin_override_out,
    // Slow crystal oscillator core and pins
    output logic        lf_xtal_run_out,
    output logic        lf_xtal_mode_out,
    output logic        lf_xtal_clk_valid_out,
    output logic        lf_xtal_32k_en_out,
    output logic        lf_in_pin_override_out,
    output logic        lf_out_pin_override_out,
    // RC oscillator
    output logic        lf_rc_run_out,
    output logic        lf_rc_clk_valid_out,
    output logic        lf_rc_32k_en_out,
    output logic [occ_pkg::OCC_TRIM_W-1:0] lf_rc_trim_out,
    // Ultra-low-power oscillator
    output logic        ulp_32k_en_out,
    output logic        ulp_1k_en_out,
    output logic [occ_pkg::OCC_ULP_TRIM_W-1:0] ulp_trim_out,
    // Interrupt
    output logic        irq_out
);
    import occ_pkg::*;

    logic                  hard_rst;
    logic                  wr_hf, wr_lfx, wr_lfr, wr_ulp;
    logic                  wr_ies, wr_iec, wr_flg;

    logic                  hf_en_r, hf_xtal_r, hf_amp_r, hf_rs_r, hf_od_r;
    logic [OCC_GAIN_W-1:0] hf_gain_r;
    logic [OCC_SEL_W-1:0]  hf_sel_r;
    logic                  lfx_en_r, lfx_xtal_r, lfx_32k_r;
    logic [OCC_SEL_W-1:0]  lfx_sel_r;
    logic                  lfr_en_r, lfr_32k_r, lfr_rs_r, lfr_od_r;
    logic [OCC_SEL_W-1:0]  lfr_sel_r;
    logic [OCC_TRIM_W-1:0] lfr_trim_pend_r;
    logic [OCC_TRIM_W-1:0] lfr_trim_r;
    logic [OCC_ULP_TRIM_W-1:0] ulp_trim_r;
    logic                  ulp_load_r;

    logic [OCC_NSRC-1:0]   ready;
    logic [OCC_NSRC-1:0]   ready_q_r;
    logic [OCC_NSRC-1:0]   irq_en_r;
    logic [OCC_NSRC-1:0]   irq_flag_r;
    logic [OCC_NSRC-1:0]   rise;
    logic [OCC_NSRC-1:0]   src_run;
    logic                  hf_run, lfr_run;
    logic [31:0]           rdata_r;
    logic [31:0]           rdata_nxt;

    // Non-power-on resets restart everything but the slow crystal, the ULP oscillator and trim, and the delayed ready copy
    assign hard_rst = rst_in || sys_rst_in;

    assign wr_hf  = reg_wr_in && (reg_addr_in == OCC_ADDR_HF_CTRL);
    assign wr_lfx = reg_wr_in && (reg_addr_in == OCC_ADDR_LFX_CTRL);
    assign wr_lfr = reg_wr_in && (reg_addr_in == OCC_ADDR_LFR_CTRL);
    assign wr_ulp = reg_wr_in && (reg_addr_in == OCC_ADDR_ULP_CTRL);
    assign wr_ies = reg_wr_in && (reg_addr_in == OCC_ADDR_IE_SET);
    assign wr_iec = reg_wr_in && (reg_addr_in == OCC_ADDR_IE_CLR);
    assign wr_flg = reg_wr_in && (reg_addr_in == OCC_ADDR_IRQ_FLAG);

    // Fast oscillator control; gain is the software's job in crystal mode
    always_ff @(posedge clk_sys_in)
    begin
        if (hard_rst)
        begin
            hf_en_r   <= 1'b0;
            hf_xtal_r <= 1'b0;
            hf_amp_r  <= 1'b0;
            hf_rs_r   <= 1'b0;
            hf_od_r   <= OCC_REQUEST_GATED_RUN_RST;
            hf_gain_r <= OCC_GAIN_RST;
            hf_sel_r  <= OCC_SEL_RST;
        end
        else if (wr_hf)
        begin
            hf_en_r   <= reg_wdata_in[OCC_B_ENABLE];
            hf_xtal_r <= reg_wdata_in[OCC_B_XTAL];
            hf_amp_r  <= reg_wdata_in[OCC_B_AUTOAMP];
            hf_rs_r   <= reg_wdata_in[OCC_B_RUN_IN_STANDBY];
            hf_od_r   <= reg_wdata_in[OCC_B_REQUEST_GATED_RUN];
            hf_gain_r <= reg_wdata_in[OCC_GAIN_LSB +: OCC_GAIN_W];
            hf_sel_r  <= reg_wdata_in[OCC_HF_SEL_LSB +: OCC_SEL_W];
        end
    end

    // Slow crystal keeps its setup through every reset but power-on
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            lfx_en_r   <= 1'b0;
            lfx_xtal_r <= 1'b0;
            lfx_32k_r  <= 1'b0;
            lfx_sel_r  <= OCC_SEL_RST;
        end
        else if (wr_lfx)
        begin
            // Mixed enable and field writes are taken as written
            lfx_en_r   <= reg_wdata_in[OCC_B_ENABLE];
            lfx_xtal_r <= reg_wdata_in[OCC_B_XTAL];
            lfx_32k_r  <= reg_wdata_in[OCC_B_OUT32K];
            lfx_sel_r  <= reg_wdata_in[OCC_LF_SEL_LSB +: OCC_SEL_W];
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (hard_rst)
        begin
            lfr_en_r        <= 1'b0;
            lfr_32k_r       <= 1'b0;
            lfr_rs_r        <= 1'b0;
            lfr_od_r        <= OCC_REQUEST_GATED_RUN_RST;
            lfr_sel_r       <= OCC_SEL_RST;
            lfr_trim_pend_r <= '0;
        end
        else if (wr_lfr)
        begin
            lfr_en_r        <= reg_wdata_in[OCC_B_ENABLE];
            lfr_32k_r       <= reg_wdata_in[OCC_B_OUT32K];
            lfr_rs_r        <= reg_wdata_in[OCC_B_RUN_IN_STANDBY];
            lfr_od_r        <= reg_wdata_in[OCC_B_REQUEST_GATED_RUN];
            lfr_sel_r       <= reg_wdata_in[OCC_LF_SEL_LSB +: OCC_SEL_W];
            lfr_trim_pend_r <= reg_wdata_in[OCC_TRIM_LSB +: OCC_TRIM_W];
        end
    end

    // Trim reaches the RC core only while it reports ready
    always_ff @(posedge clk_sys_in)
    begin
        if (hard_rst)
            lfr_trim_r <= '0;
        else if (ready[OCC_ST_LFR])
            lfr_trim_r <= lfr_trim_pend_r;
    end

    // Fuse trim is captured on the first cycle after power-on release
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            ulp_load_r <= 1'b1;
        else
            ulp_load_r <= 1'b0;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            ulp_trim_r <= '0;
        else if (ulp_load_r)
            ulp_trim_r <= ulp_trim_fuse_in;
        else if (wr_ulp)
            ulp_trim_r <= reg_wdata_in[OCC_ULP_TRIM_W-1:0];
    end

    occ_run_decode u_hf_run
    (
        .enable_in    (hf_en_r),
        .run_stdby_in (hf_rs_r),
        .on_demand_in (hf_od_r),
        .idle_in      (sleep_idle_in),
        .standby_in   (sleep_standby_in),
        .request_in   (hf_clk_req_in),
        .run_out      (hf_run)
    );

    occ_run_decode u_lfr_run
    (
        .enable_in    (lfr_en_r),
        .run_stdby_in (lfr_rs_r),
        .on_demand_in (lfr_od_r),
        .idle_in      (sleep_idle_in),
        .standby_in   (sleep_standby_in),
        .request_in   (lf_rc_clk_req_in),
        .run_out      (lfr_run)
    );

    assign src_run[OCC_ST_HF]  = hf_run;
    assign src_run[OCC_ST_LFX] = lfx_en_r;
    assign src_run[OCC_ST_LFR] = lfr_run;

    // Slow crystal timer sits on power-on reset only so it keeps running
    occ_startup_timer #(
        .CW   (OCC_CNT_W),
        .SW   (OCC_SEL_W),
        .BASE (STARTUP_BASE)
    ) u_hf_tmr (
        .clk_sys_in (clk_sys_in),
        .rst_in     (hard_rst),
        .run_in     (src_run[OCC_ST_HF]),
        .sel_in     (hf_sel_r),
        .ready_out  (ready[OCC_ST_HF])
    );

    occ_startup_timer #(
        .CW   (OCC_CNT_W),
        .SW   (OCC_SEL_W),
        .BASE (STARTUP_BASE)
    ) u_lfx_tmr (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .run_in     (src_run[OCC_ST_LFX]),
        .sel_in     (lfx_sel_r),
        .ready_out  (ready[OCC_ST_LFX])
    );

    occ_startup_timer #(
        .CW   (OCC_CNT_W),
        .SW   (OCC_SEL_W),
        .BASE (STARTUP_BASE)
    ) u_lfr_tmr (
        .clk_sys_in (clk_sys_in),
        .rst_in     (hard_rst),
        .run_in     (src_run[OCC_ST_LFR]),
        .sel_in     (lfr_sel_r),
        .ready_out  (ready[OCC_ST_LFR])
    );

    // Ready edges become sticky flags; a new edge beats a clear
    // The delayed copy follows power-on only: a slow crystal that stays
    // ready through a warm reset must not look like a fresh edge
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            ready_q_r <= '0;
        else
            ready_q_r <= ready;
    end

    assign rise = ready & ~ready_q_r;

    always_ff @(posedge clk_sys_in)
    begin
        if (hard_rst)
            irq_flag_r <= '0;
        else if (wr_flg)
            irq_flag_r <= (irq_flag_r & ~reg_wdata_in[OCC_NSRC-1:0]) | rise;
        else
            irq_flag_r <= irq_flag_r | rise;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (hard_rst)
            irq_en_r <= '0;
        else if (wr_ies)
            irq_en_r <= irq_en_r | reg_wdata_in[OCC_NSRC-1:0];
        else if (wr_iec)
            irq_en_r <= irq_en_r & ~reg_wdata_in[OCC_NSRC-1:0];
    end

    assign irq_out = |(irq_flag_r & irq_en_r);

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = '0;
        case (reg_addr_in)
            OCC_ADDR_HF_CTRL:
            begin
                rdata_nxt[OCC_B_ENABLE]   = hf_en_r;
                rdata_nxt[OCC_B_XTAL]     = hf_xtal_r;
                rdata_nxt[OCC_B_AUTOAMP]  = hf_amp_r;
                rdata_nxt[OCC_B_RUN_IN_STANDBY] = hf_rs_r;
                rdata_nxt[OCC_B_REQUEST_GATED_RUN] = hf_od_r;
                rdata_nxt[OCC_GAIN_LSB +: OCC_GAIN_W]  = hf_gain_r;
                rdata_nxt[OCC_HF_SEL_LSB +: OCC_SEL_W] = hf_sel_r;
            end
            OCC_ADDR_LFX_CTRL:
            begin
                rdata_nxt[OCC_B_ENABLE] = lfx_en_r;
                rdata_nxt[OCC_B_XTAL]   = lfx_xtal_r;
                rdata_nxt[OCC_B_OUT32K] = lfx_32k_r;
                rdata_nxt[OCC_LF_SEL_LSB +: OCC_SEL_W] = lfx_sel_r;
            end
            OCC_ADDR_LFR_CTRL:
            begin
                rdata_nxt[OCC_B_ENABLE]   = lfr_en_r;
                rdata_nxt[OCC_B_OUT32K]   = lfr_32k_r;
                rdata_nxt[OCC_B_RUN_IN_STANDBY] = lfr_rs_r;
                rdata_nxt[OCC_B_REQUEST_GATED_RUN] = lfr_od_r;
                rdata_nxt[OCC_LF_SEL_LSB +: OCC_SEL_W]  = lfr_sel_r;
                rdata_nxt[OCC_TRIM_LSB +: OCC_TRIM_W]   = lfr_trim_pend_r;
            end
            OCC_ADDR_ULP_CTRL: rdata_nxt[OCC_ULP_TRIM_W-1:0] = ulp_trim_r;
            OCC_ADDR_STATUS:   rdata_nxt[OCC_NSRC-1:0] = ready;
            OCC_ADDR_IE_SET:   rdata_nxt[OCC_NSRC-1:0] = irq_en_r;
            OCC_ADDR_IE_CLR:   rdata_nxt[OCC_NSRC-1:0] = irq_en_r;
            OCC_ADDR_IRQ_FLAG: rdata_nxt[OCC_NSRC-1:0] = irq_flag_r;
            default:           rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (hard_rst || !reg_rd_in)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata_out = rdata_r;

    // Core controls and pin takeover
    assign hf_osc_run_out          = hf_run;
    assign hf_xtal_mode_out        = hf_xtal_r;
    assign hf_drive_gain_out       = hf_gain_r;
    assign hf_auto_amp_out         = hf_amp_r && hf_xtal_r;
    assign hf_clk_valid_out        = ready[OCC_ST_HF];
    assign hf_in_pin_override_out  = hf_en_r;
    assign hf_out_pin_override_out = hf_en_r && hf_xtal_r;

    assign lf_xtal_run_out         = lfx_en_r;
    assign lf_xtal_mode_out        = lfx_xtal_r;
    assign lf_xtal_clk_valid_out   = ready[OCC_ST_LFX];
    // External clock on the slow pin cannot feed the 32k output
    assign lf_xtal_32k_en_out      = ready[OCC_ST_LFX] && lfx_32k_r &&
                                     lfx_xtal_r;
    assign lf_in_pin_override_out  = lfx_en_r;
    assign lf_out_pin_override_out = lfx_en_r && lfx_xtal_r;

    assign lf_rc_run_out           = lfr_run;
    assign lf_rc_clk_valid_out     = ready[OCC_ST_LFR];
    assign lf_rc_32k_en_out        = ready[OCC_ST_LFR] && lfr_32k_r;
    assign lf_rc_trim_out          = lfr_trim_r;

    assign ulp_32k_en_out          = !rst_in;
    assign ulp_1k_en_out           = !rst_in;
    assign ulp_trim_out            = ulp_trim_r;

    // Standby entry during start-up is left to software
    sequence s_hf_start;
        $rose(hf_run);
    endsequence

    sequence s_hf_masked;
        !hf_clk_valid_out [*2];
    endsequence

    AST_RESET_OFF: assert property (@(posedge clk_sys_in)
        hard_rst |=> !hf_in_pin_override_out && !hf_out_pin_override_out)
        else $error("fast oscillator pins claimed after reset");
    AST_XTAL_PINS: assert property (@(posedge clk_sys_in)
        disable iff (hard_rst)
        hf_en_r && hf_xtal_r |-> hf_in_pin_override_out &&
                                 hf_out_pin_override_out)
        else $error("crystal mode did not take both pins");
    AST_EXT_PINS: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        lfx_en_r && !lfx_xtal_r |-> lf_in_pin_override_out &&
                                    !lf_out_pin_override_out)
        else $error("external mode pin takeover wrong");
    AST_DIS_OFF: assert property (@(posedge clk_sys_in)
        disable iff (hard_rst)
        !hf_en_r |-> !hf_osc_run_out && !hf_clk_valid_out)
        else $error("disabled fast oscillator running");
    AST_STBY_RUN: assert property (@(posedge clk_sys_in)
        disable iff (hard_rst)
        hf_en_r && hf_rs_r && !hf_od_r && sleep_standby_in |-> hf_osc_run_out)
        else $error("fast oscillator stopped in standby");
    AST_STBY_GATED: assert property (@(posedge clk_sys_in)
        disable iff (hard_rst)
        sleep_standby_in && hf_od_r && !hf_clk_req_in |-> !hf_osc_run_out)
        else $error("gated fast oscillator ran without request");
    AST_START_MASK: assert property (@(posedge clk_sys_in)
        disable iff (hard_rst)
        s_hf_start |-> s_hf_masked)
        else $error("clock unmasked during start-up");
    AST_READY_IRQ: assert property (@(posedge clk_sys_in)
        disable iff (hard_rst)
        $rose(ready[OCC_ST_HF]) && irq_en_r[OCC_ST_HF] |=> irq_out)
        else $error("ready edge gave no interrupt");
    AST_LFX_KEEP: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        sys_rst_in && lfx_en_r && !wr_lfx |=> lfx_en_r)
        else $error("slow crystal lost enable on warm reset");
    AST_DIS_READY: assert property (@(posedge clk_sys_in)
        disable iff (hard_rst)
        $fell(hf_en_r) |=> !ready[OCC_ST_HF])
        else $error("ready stayed after disable");
    AST_ULP_ON: assert property (@(posedge clk_sys_in)
        !rst_in |-> ulp_32k_en_out && ulp_1k_en_out)
        else $error("ULP outputs off outside power-on reset");
endmodule // occ_osc_ctrl
`default_nettype wire

// file: src/occ_run_decode.sv
`timescale 1ns/1ps
`default_nettype none
module occ_run_decode
(
    // Configuration
    input  wire logic enable_in,
    input  wire logic run_stdby_in,
    input  wire logic on_demand_in,
    // Power state and demand
    input  wire logic idle_in,
    input  wire logic standby_in,
    input  wire logic request_in,
    // Result
    output logic      run_out
);
    logic demand_ok;

    assign demand_ok = !on_demand_in || request_in;

    always_comb
    begin
        if (!enable_in)
            run_out = 1'b0;
        else if (standby_in)
            run_out = run_stdby_in && demand_ok;
        else if (idle_in)
            run_out = demand_ok;
        else
            run_out = 1'b1;
    end
endmodule // occ_run_decode
`default_nettype wire

// file: src/occ_startup_timer.sv
`timescale 1ns/1ps
`default_nettype none
module occ_startup_timer
#(
    parameter int                 CW   = 24,
    parameter int                 SW   = 4,
    parameter logic [CW-1:0]      BASE = 24'h000010
)
(
    // Clock and reset
    input  wire logic          clk_sys_in,
    input  wire logic          rst_in,
    // Control
    input  wire logic          run_in,
    input  wire logic [SW-1:0] sel_in,
    // Status
    output logic               ready_out
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] limit;
    logic          done_r;

    assign limit     = BASE << sel_in;
    // Ready falls with the run itself, so a stop masks the clock at once
    assign ready_out = done_r && run_in;

    // Any stop restarts the wait, so a wake from an off state masks again
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || !run_in)
            cnt_r <= '0;
        else if (!done_r)
            cnt_r <= cnt_r + 1'b1;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || !run_in)
            done_r <= 1'b0;
        else if (cnt_r == limit - 1'b1)
            done_r <= 1'b1;
    end
endmodule // occ_startup_timer
`default_nettype wire

// file: verification/occ_xtal_model.sv
`timescale 1ns/1ps
`default_nettype none
module occ_xtal_model
(
    // Clock and pin control
    input  wire logic clk_sys_in,
    input  wire logic in_ovr_in,
    input  wire logic out_ovr_in,
    // Wire level at the input pin
    output logic      pin_out
);
    logic tog_r = 1'b0;
    always_ff @(posedge clk_sys_in)
        tog_r <= ~tog_r;
    // Crystal swings only while both pins are claimed; else pulled low
    assign pin_out = (in_ovr_in && out_ovr_in) ? tog_r : 1'b0;
endmodule // occ_xtal_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
    import occ_pkg::*;
    logic clk_sys_in, rst_in, srst, wr, rd, idle, stby, hreq, rreq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, lfsr_r, v;
    logic [4:0] fuse, ut;
    logic [6:0] rt, t;
    logic [2:0] hg, g;
    logic hrun, hxm, haa, hv, hio, hoo, lrun, lxm, lv, l32, lio, loo;
    logic rrun, rv, r32, u32, u1k, irq, pin, pb;
    int err_count, checked, k;
    occ_osc_ctrl #(.STARTUP_BASE(24'h000002)) DUT (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .sys_rst_in(srst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .sleep_idle_in(idle), .sleep_standby_in(stby),
        .hf_clk_req_in(hreq), .lf_rc_clk_req_in(rreq), .ulp_trim_fuse_in(fuse),
        .hf_osc_run_out(hrun), .hf_xtal_mode_out(hxm), .hf_drive_gain_out(hg),
        .hf_auto_amp_out(haa), .hf_clk_valid_out(hv),
        .hf_in_pin_override_out(hio), .hf_out_pin_override_out(hoo),
        .lf_xtal_run_out(lrun), .lf_xtal_mode_out(lxm),
        .lf_xtal_clk_valid_out(lv), .lf_xtal_32k_en_out(l32),
        .lf_in_pin_override_out(lio), .lf_out_pin_override_out(loo),
        .lf_rc_run_out(rrun), .lf_rc_clk_valid_out(rv),
        .lf_rc_32k_en_out(r32), .lf_rc_trim_out(rt), .ulp_32k_en_out(u32),
        .ulp_1k_en_out(u1k), .ulp_trim_out(ut), .irq_out(irq));
    occ_xtal_model XM (.clk_sys_in(clk_sys_in), .in_ovr_in(hio),
        .out_ovr_in(hoo), .pin_out(pin));
    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction
    function automatic logic exp_run(logic e, q, s, r, i, sb);
        return e & (sb ? s & (!q | r) : (i ? (!q | r) : 1'b1));
    endfunction
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk_sys_in); wr <= 1'b0; #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in); addr <= a; rd <= 1'b1;
        @(posedge clk_sys_in); rd <= 1'b0; #1; d = rdata;
    endtask
    // Polls status with a bound so a flag that never rises cannot hang
    task automatic wait_st(input int b);
        for (int i = 0; i < 100; i++) begin rd_reg(OCC_ADDR_STATUS, v);
            if (v[b] === 1'b1) break; end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin clk_sys_in = 1'b0; forever #2 clk_sys_in = ~clk_sys_in; end
    initial begin #40000; err_count++; print_verdict(); end
    initial
    begin
        {srst, wr, rd, idle, stby, hreq, rreq, addr, wdata} = '0;
        rst_in = 1'b1; fuse = 5'h0b; lfsr_r = 32'h365553af;
        err_count = 0; checked = 0;
        repeat (3) @(posedge clk_sys_in); rst_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in); #1;
        `CHK("ulp", 7'h0b, {u32, u1k, ut} ^ 7'h60)
        `CHK("idle pins", 7'h0, {hrun, hio, hoo, lrun, lio, loo, rrun})
        rd_reg(OCC_ADDR_HF_CTRL, v); `CHK("hf ctrl", 32'h80, v)
        v = rnd(); g = v[2:0]; wr_reg(OCC_ADDR_HF_CTRL, {g, 8'h26});
        `CHK("hf xtal", 7'h7a, {hio, hoo, hxm, haa, hv, 2'b10})
        `CHK("gain", g, hg)
        pb = pin; @(posedge clk_sys_in); #1;
        `CHK("xtal swing", ~pb, pin)
        wr_reg(OCC_ADDR_IE_SET, 1);
        wait_st(OCC_ST_HF); `CHK("hf ready", 1'b1, v[0])
        repeat (2) @(posedge clk_sys_in); #1;
        `CHK("hf irq", 2'b11, {irq, hv})
        wr_reg(OCC_ADDR_IE_CLR, 1); wr_reg(OCC_ADDR_IRQ_FLAG, 1);
        $display("test crystal done");
        for (k = 0; k < 32; k++)
        begin
            v = rnd(); idle <= k[2]; stby <= k[3]; hreq <= v[0];
            wr_reg(OCC_ADDR_HF_CTRL, {k[4], k[0], 3'h0, k[1], 2'h2});
            @(posedge clk_sys_in); #1;
            `CHK("hf run", exp_run(1, k[4], k[0], v[0], k[2], k[3]), hrun)
            wr_reg(OCC_ADDR_HF_CTRL, 0); #1; `CHK("off", 1'b0, hrun)
        end
        {idle, stby} <= 2'b00;
        wr_reg(OCC_ADDR_HF_CTRL, 32'h2); `CHK("ext pins", 2'b10, {hio, hoo})
        wait_st(OCC_ST_HF); wr_reg(OCC_ADDR_HF_CTRL, 0);
        rd_reg(OCC_ADDR_STATUS, v); `CHK("hf drop", 2'b00, {v[0], hv})
        `CHK("pin idle", 1'b0, pin)
        $display("test run modes done");
        wr_reg(OCC_ADDR_LFX_CTRL, 32'he); wait_st(OCC_ST_LFX);
        `CHK("lf 32k", 1'b1, l32)
        stby <= 1'b1; srst <= 1'b1; repeat (2) @(posedge clk_sys_in);
        srst <= 1'b0; @(posedge clk_sys_in); #1;
        `CHK("lf keep", 5'h1f, {lrun, lv, lio, loo, lxm})
        rd_reg(OCC_ADDR_LFX_CTRL, v); `CHK("lfx ctrl", 32'he, v)
        wr_reg(OCC_ADDR_LFX_CTRL, 32'hc); wr_reg(OCC_ADDR_LFX_CTRL, 32'h8);
        wr_reg(OCC_ADDR_LFX_CTRL, 32'ha); wait_st(OCC_ST_LFX);
        `CHK("lf ext", 3'b110, {lio, lv, l32 | loo})
        stby <= 1'b0; $display("test slow crystal done");
        v = rnd(); t = v[6:0];
        wr_reg(OCC_ADDR_LFR_CTRL, {9'h0, t, 16'h000a});
        wait_st(OCC_ST_LFR); repeat (2) @(posedge clk_sys_in); #1;
        `CHK("rc trim", t, rt)
        `CHK("rc 32k", 3'b111, {r32, rrun, rv})
        wr_reg(OCC_ADDR_ULP_CTRL, 32'h15); `CHK("ulp wr", 5'h15, ut)
        rd_reg(8'h20, v); `CHK("unmapped", 32'h0, v)
        $display("test rc and ulp done");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
